// ---- shared/dmacf_pkg.sv ----
// Constants for one DMA channel's control fields and its small transfer sequencer.
// Assumes a single 10 MHz system clock and a plain strobed register port.
`default_nettype none
package dmacf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RADDR = 8'h04;
  localparam logic [7:0] OFF_WADDR = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0c;
  // Control word field positions
  localparam int EN_BIT = 0;
  localparam int HIPRI_BIT = 1;
  localparam int SIZE_LSB = 2;
  localparam int RINC_BIT = 4;
  localparam int WINC_BIT = 5;
  localparam int RSIZE_LSB = 6;
  localparam int RSEL_BIT = 10;
  localparam int CHAIN_LSB = 11;
  localparam int PACE_LSB = 15;
  localparam int BUSY_BIT = 24;
  localparam int CFG_W = 21;
  localparam logic [20:0] CFG_RESET = 21'h001800;
  localparam logic [3:0] OWN_CHANNEL = 4'h3;
  // Pacing source codes
  localparam logic [5:0] PACE_PERIPH_MAX = 6'h3a;
  localparam logic [5:0] PACE_TIMER0 = 6'h3b;
  localparam logic [5:0] PACE_TIMER1 = 6'h3c;
  localparam logic [5:0] PACE_TIMER2 = 6'h3d;
  localparam logic [5:0] PACE_TIMER3 = 6'h3e;
  localparam logic [5:0] PACE_ALWAYS = 6'h3f;
  // Transfer sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_XFER = 3'b100
  } dmacf_state_type;
endpackage : dmacf_pkg
`default_nettype wire

// ---- rtl/dmacf_channel.sv ----
// One DMA channel: control word, address registers, pacing select and sequencer.
// Assumes peripheral requests, timers and the bus side run on mclk_in.
// Overview of operation
// - Pacing codes 0x0..0x3a pick the peripheral request line of that index.
// - Code 0x3b picks timer 0, 0x3d timer 2, 0x3e timer 3.
// - Code 0x3f means a request is always present, unpaced.
// - A transfer is issued only while the selected pacing request allows.
// - On completion the channel triggers the channel named in the chain target.
// - Chain target equal to own number 3 disables chaining; resets to 3.
// - Ring select bit wraps read addresses when clear, write addresses when set.
// - Ring size zero disables wrapping; n keeps the address in 2^n bytes.
// - Wrap regions from 2 to 32768 bytes, naturally aligned.
// - Write increment set advances the write address every transfer.
// - Read increment set advances the read address every transfer.
// - Size field selects byte, halfword or word transfers.
// - Addresses advance by 1, 2 or 4 bytes matching the size.
// - Scheduler serves all high priority channels, then one low priority channel.
// - Priority changes issue order only, not the bus priority.
// - Enable set lets triggers start a sequence and make the channel busy.
// - Enable clear ignores triggers, stops issue, pauses with busy held.
// - Busy rises at sequence start, falls when the last transfer completes.
`timescale 1ns/1ps
`default_nettype none
module dmacf_channel #(
  parameter int REQ_LINES = 59,
  parameter int COUNT_W = 32
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [REQ_LINES-1:0] peripheral_data_request_in,
  input wire logic [3:0] timer_tick_in,
  input wire logic chain_trigger_in,
  input wire logic xfer_done_in,
  output logic xfer_req_out,
  output logic [31:0] xfer_read_addr_out,
  output logic [31:0] xfer_write_addr_out,
  output logic [1:0] xfer_size_out,
  output logic high_priority_out,
  output logic busy_out,
  output logic chain_trigger_out,
  output logic [3:0] chain_target_out
);
  if (REQ_LINES < 59 || REQ_LINES > 64 || COUNT_W < 1 || COUNT_W > 32) begin : g_chk
    $error("dmacf_channel: unsupported parameter values");
  end

  function automatic logic [31:0] ring_next(input logic [31:0] old_a, input logic [31:0] step,
                                            input logic [3:0] n, input logic wrap);
    logic [31:0] mask;
    logic [31:0] sum;
    begin
      mask = (32'h1 << n) - 32'h1;
      sum = old_a + step;
      ring_next = (wrap && n != 4'h0) ? ((old_a & ~mask) | (sum & mask)) : sum;
    end
  endfunction : ring_next

  logic [20:0] cfg_ff;
  logic [31:0] raddr_ff;
  logic [31:0] waddr_ff;
  logic [COUNT_W-1:0] count_ff;
  logic [COUNT_W-1:0] remain_ff;
  logic [31:0] rdata_ff;
  logic chain_ff;
  logic [3:0] chain_tgt_ff;
  dmacf_pkg::dmacf_state_type state_ff;
  dmacf_pkg::dmacf_state_type nxt_state;

  wire en = cfg_ff[dmacf_pkg::EN_BIT];
  wire [1:0] size = cfg_ff[dmacf_pkg::SIZE_LSB +: 2];
  wire rinc = cfg_ff[dmacf_pkg::RINC_BIT];
  wire winc = cfg_ff[dmacf_pkg::WINC_BIT];
  wire [3:0] ring_n = cfg_ff[dmacf_pkg::RSIZE_LSB +: 4];
  wire ring_sel = cfg_ff[dmacf_pkg::RSEL_BIT];
  wire [3:0] chain_tgt = cfg_ff[dmacf_pkg::CHAIN_LSB +: 4];
  wire [5:0] pace_sel = cfg_ff[dmacf_pkg::PACE_LSB +: 6];

  wire wr_ctrl = reg_wr_in && reg_addr_in == dmacf_pkg::OFF_CTRL;
  wire wr_raddr = reg_wr_in && reg_addr_in == dmacf_pkg::OFF_RADDR;
  wire wr_waddr = reg_wr_in && reg_addr_in == dmacf_pkg::OFF_WADDR;
  wire wr_count = reg_wr_in && reg_addr_in == dmacf_pkg::OFF_COUNT;

  // Timer 1 takes the spare code 0x3c, keeping 0x3d for timer 2
  wire pace_req =
    (pace_sel <= dmacf_pkg::PACE_PERIPH_MAX) ? peripheral_data_request_in[pace_sel] :
    (pace_sel == dmacf_pkg::PACE_TIMER0) ? timer_tick_in[0] :
    (pace_sel == dmacf_pkg::PACE_TIMER1) ? timer_tick_in[1] :
    (pace_sel == dmacf_pkg::PACE_TIMER2) ? timer_tick_in[2] :
    (pace_sel == dmacf_pkg::PACE_TIMER3) ? timer_tick_in[3] :
    1'b1;

  // Reserved size code 3 is treated as word
  wire [31:0] step = (size == dmacf_pkg::SIZE_BYTE) ? 32'h1 :
                     (size == dmacf_pkg::SIZE_HALF) ? 32'h2 : 32'h4;

  // A write of the control word with enable set is itself a trigger
  wire trig = (wr_ctrl && reg_wdata_in[dmacf_pkg::EN_BIT]) || (chain_trigger_in && en);
  wire start = state_ff == dmacf_pkg::ST_IDLE && trig && count_ff != '0;
  wire done = state_ff == dmacf_pkg::ST_XFER && xfer_done_in;
  wire last = done && remain_ff == COUNT_W'(1);
  wire busy = state_ff != dmacf_pkg::ST_IDLE;

  wire [31:0] raddr_nxt = rinc ? ring_next(raddr_ff, step, ring_n, !ring_sel)
                               : raddr_ff;
  wire [31:0] waddr_nxt = winc ? ring_next(waddr_ff, step, ring_n, ring_sel)
                               : waddr_ff;

  wire [31:0] ctrl_view = {7'h0, busy, 3'h0, cfg_ff};
  wire [31:0] rd_mux =
    (reg_addr_in == dmacf_pkg::OFF_CTRL) ? ctrl_view :
    (reg_addr_in == dmacf_pkg::OFF_RADDR) ? raddr_ff :
    (reg_addr_in == dmacf_pkg::OFF_WADDR) ? waddr_ff :
    (reg_addr_in == dmacf_pkg::OFF_COUNT) ? 32'(count_ff) : 32'h0;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      dmacf_pkg::ST_IDLE: begin
        if (start) begin
          nxt_state = dmacf_pkg::ST_WAIT;
        end
      end
      dmacf_pkg::ST_WAIT: begin
        if (en && pace_req) begin
          nxt_state = dmacf_pkg::ST_XFER;
        end
      end
      dmacf_pkg::ST_XFER: begin
        if (last) begin
          nxt_state = dmacf_pkg::ST_IDLE;
        end else if (done) begin
          nxt_state = dmacf_pkg::ST_WAIT;
        end
      end
      default: nxt_state = dmacf_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      state_ff <= dmacf_pkg::ST_IDLE;
      cfg_ff <= dmacf_pkg::CFG_RESET;
    end else begin
      state_ff <= nxt_state;
      if (wr_ctrl) begin
        cfg_ff <= reg_wdata_in[dmacf_pkg::CFG_W-1:0];
      end
    end
  end

  // Software writes win over the hardware advance in the same cycle
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      raddr_ff <= 32'h0;
      waddr_ff <= 32'h0;
    end else begin
      raddr_ff <= wr_raddr ? reg_wdata_in : (done ? raddr_nxt : raddr_ff);
      waddr_ff <= wr_waddr ? reg_wdata_in : (done ? waddr_nxt : waddr_ff);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      count_ff <= '0;
      remain_ff <= '0;
    end else begin
      if (wr_count) begin
        count_ff <= reg_wdata_in[COUNT_W-1:0];
      end
      remain_ff <= start ? count_ff : (done ? remain_ff - COUNT_W'(1) : remain_ff);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      chain_ff <= 1'b0;
      chain_tgt_ff <= dmacf_pkg::OWN_CHANNEL;
      rdata_ff <= 32'h0;
    end else begin
      chain_ff <= last && chain_tgt != dmacf_pkg::OWN_CHANNEL;
      chain_tgt_ff <= last ? chain_tgt : chain_tgt_ff;
      rdata_ff <= reg_rd_in ? rd_mux : 32'h0;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign xfer_req_out = state_ff == dmacf_pkg::ST_XFER;
  assign xfer_read_addr_out = raddr_ff;
  assign xfer_write_addr_out = waddr_ff;
  assign xfer_size_out = size;
  // Only orders issue in the outside scheduler; bus priority untouched
  assign high_priority_out = cfg_ff[dmacf_pkg::HIPRI_BIT];
  assign busy_out = busy;
  assign chain_trigger_out = chain_ff;
  assign chain_target_out = chain_tgt_ff;

  // Pause length, watched only by the long-pause check
  logic [2:0] pause_cnt_ff;
  wire paused = state_ff == dmacf_pkg::ST_WAIT && !en;
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      pause_cnt_ff <= 3'h0;
    end else if (!paused) begin
      pause_cnt_ff <= 3'h0;
    end else if (!(&pause_cnt_ff)) begin
      pause_cnt_ff <= pause_cnt_ff + 3'h1;
    end
  end

  a_periph_select: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    pace_sel <= dmacf_pkg::PACE_PERIPH_MAX |-> pace_req == peripheral_data_request_in[pace_sel])
    else $error("pacing request does not follow selected peripheral line");
  a_timer_select: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    pace_sel == dmacf_pkg::PACE_TIMER0 |-> pace_req == timer_tick_in[0])
    else $error("timer 0 pacing not selected");
  a_unpaced_issue: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state_ff == dmacf_pkg::ST_WAIT && en && pace_sel == dmacf_pkg::PACE_ALWAYS |=> xfer_req_out)
    else $error("unpaced channel did not issue");
  a_paced_hold: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state_ff == dmacf_pkg::ST_WAIT && !pace_req |=> !xfer_req_out)
    else $error("transfer issued without pacing request");
  a_chain_fire: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    last && chain_tgt != dmacf_pkg::OWN_CHANNEL |=>
      chain_trigger_out && chain_target_out == $past(chain_tgt))
    else $error("chain trigger missing after completion");
  a_chain_off: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !(last && chain_tgt != dmacf_pkg::OWN_CHANNEL) |=> !chain_trigger_out)
    else $error("chain trigger without enabled chaining");
  a_write_step: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    done && winc && ring_n == 4'h0 && !wr_waddr |=> waddr_ff == $past(waddr_ff) + $past(step))
    else $error("write address did not advance by transfer size");
  a_read_fixed: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    done && !rinc && !wr_raddr |=> $stable(raddr_ff))
    else $error("read address moved without increment");
  a_ring_upper: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    done && winc && ring_sel && ring_n != 4'h0 && !wr_waddr |=>
      (waddr_ff >> $past(ring_n)) == ($past(waddr_ff) >> $past(ring_n)))
    else $error("ring wrap changed upper address bits");
  a_pause_busy: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state_ff == dmacf_pkg::ST_WAIT && !en |=> busy_out && !xfer_req_out)
    else $error("paused channel lost busy or issued");
  a_busy_start: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !busy_out && wr_ctrl && reg_wdata_in[dmacf_pkg::EN_BIT] && count_ff != '0 |=> busy_out)
    else $error("enabled trigger did not start sequence");
  a_busy_end: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    last |=> !busy_out ##1 !xfer_req_out)
    else $error("busy held after last transfer");

  // Sequencing, pause and busy
  a_long_pause: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    &pause_cnt_ff |-> busy_out && !xfer_req_out)
    else $error("long pause lost busy or issued");
  a_idle_ignore: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !busy_out && !en && !wr_ctrl |=> !busy_out)
    else $error("disabled channel accepted a trigger");
  a_chain_start: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !busy_out && en && chain_trigger_in && count_ff != '0 |=> busy_out)
    else $error("chain trigger did not start sequence");
  a_pause_resume: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    paused ##1 (en && pace_req) |=> xfer_req_out)
    else $error("resumed channel did not issue");
  a_busy_hold: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    busy_out && !last |=> busy_out)
    else $error("busy fell before last transfer");
  a_busy_rise: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $rose(busy_out) |-> $past(start))
    else $error("busy rose without a sequence start");
  a_req_hold: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    xfer_req_out && !xfer_done_in |=> xfer_req_out && busy_out)
    else $error("outstanding transfer dropped");
  a_issue_gap: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    done |=> !xfer_req_out)
    else $error("transfer issued without a pacing check");

  // Pacing selection
  a_timer1_select: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    pace_sel == dmacf_pkg::PACE_TIMER1 |-> pace_req == timer_tick_in[1])
    else $error("timer 1 pacing not selected");
  a_timer2_select: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    pace_sel == dmacf_pkg::PACE_TIMER2 |-> pace_req == timer_tick_in[2])
    else $error("timer 2 pacing not selected");
  a_timer3_select: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    pace_sel == dmacf_pkg::PACE_TIMER3 |-> pace_req == timer_tick_in[3])
    else $error("timer 3 pacing not selected");
  a_always_request: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    pace_sel == dmacf_pkg::PACE_ALWAYS |-> pace_req)
    else $error("permanent request missing");
  a_paced_issue: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state_ff == dmacf_pkg::ST_WAIT && en && pace_req |=> xfer_req_out)
    else $error("paced channel did not issue");

  // Address stepping and wrap
  a_write_fixed: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    done && !winc && !wr_waddr |=> $stable(waddr_ff))
    else $error("write address moved without increment");
  a_byte_step: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    done && rinc && ring_n == 4'h0 && size == dmacf_pkg::SIZE_BYTE && !wr_raddr |=>
      raddr_ff == $past(raddr_ff) + 32'h1)
    else $error("byte read step wrong");
  a_half_step: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    done && rinc && ring_n == 4'h0 && size == dmacf_pkg::SIZE_HALF && !wr_raddr |=>
      raddr_ff == $past(raddr_ff) + 32'h2)
    else $error("halfword read step wrong");
  a_word_step: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    done && winc && ring_n == 4'h0 && size == dmacf_pkg::SIZE_WORD && !wr_waddr |=>
      waddr_ff == $past(waddr_ff) + 32'h4)
    else $error("word write step wrong");
  a_ring_unsel: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    done && rinc && ring_sel && ring_n != 4'h0 && size == dmacf_pkg::SIZE_BYTE && !wr_raddr
      |=> raddr_ff == $past(raddr_ff) + 32'h1)
    else $error("read address wrapped while ring selects writes");
  a_ring_read_upper: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    done && rinc && !ring_sel && ring_n != 4'h0 && !wr_raddr |=>
      (raddr_ff >> $past(ring_n)) == ($past(raddr_ff) >> $past(ring_n)))
    else $error("read ring wrap changed upper address bits");
  a_ring_read_low: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    done && rinc && !ring_sel && ring_n != 4'h0 && !wr_raddr |=>
      ((raddr_ff ^ ($past(raddr_ff) + $past(step))) & ((32'h1 << $past(ring_n)) - 32'h1))
        == 32'h0)
    else $error("read ring wrap lost low address bits");
  a_ring_write_low: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    done && winc && ring_sel && ring_n != 4'h0 && !wr_waddr |=>
      ((waddr_ff ^ ($past(waddr_ff) + $past(step))) & ((32'h1 << $past(ring_n)) - 32'h1))
        == 32'h0)
    else $error("write ring wrap lost low address bits");

  // Chaining
  a_chain_pulse: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    chain_trigger_out |=> !chain_trigger_out)
    else $error("chain trigger longer than one cycle");
  a_chain_own: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    chain_trigger_out |-> chain_target_out != dmacf_pkg::OWN_CHANNEL)
    else $error("chain trigger aimed at own channel");

  c_full_run: cover property (@(posedge mclk_in) disable iff (!reset_n_in) start ##[1:20] last);
  c_chain: cover property (@(posedge mclk_in) disable iff (!reset_n_in) chain_trigger_out);
  c_pause: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    busy_out && !en ##1 busy_out && en);
  c_ring_wrap: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    done && ring_n != 4'h0);
  c_paced_issue: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    state_ff == dmacf_pkg::ST_WAIT && en && pace_sel != dmacf_pkg::PACE_ALWAYS && pace_req);
endmodule : dmacf_channel
`default_nettype wire

// ---- testbench/dmacf_bus_target.sv ----
// Bus target model: answers each outstanding transfer with a one-cycle done.
// Assumes the channel holds its request until it has seen done.
`timescale 1ns/1ps
`default_nettype none
module dmacf_bus_target (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic xfer_req_in,
  input wire logic [3:0] delay_in,
  output logic xfer_done_out
);
  logic [3:0] wait_ff;
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      wait_ff <= 4'h0;
      xfer_done_out <= 1'b0;
    end else begin
      xfer_done_out <= 1'b0;
      // Slow answers stretch each transfer by delay_in cycles
      if (xfer_req_in && !xfer_done_out) begin
        if (wait_ff >= delay_in) begin
          xfer_done_out <= 1'b1;
          wait_ff <= 4'h0;
        end else begin
          wait_ff <= wait_ff + 4'h1;
        end
      end
    end
  end
endmodule : dmacf_bus_target
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Testbench for one DMA channel's control fields and sequencer.
// Assumes the bus target model answers transfers; pacing lines driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [58:0] preq = '0;
  logic [3:0] tick = 4'h0;
  logic chain_in = 1'b0;
  logic [3:0] delay = 4'h0;
  logic done, req, hp, busy, chain_out;
  logic [31:0] rdata, raddr, waddr, got;
  logic [1:0] size;
  logic [3:0] chain_tgt;
  logic [5:0] codes [6] = '{6'h00, 6'h3a, 6'h3b, 6'h3c, 6'h3d, 6'h3e};
  int mismatches = 0;
  int checks_done = 0;
  int chain_seen = 0;
  dmacf_channel dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .peripheral_data_request_in(preq), .timer_tick_in(tick), .chain_trigger_in(chain_in),
    .xfer_done_in(done), .xfer_req_out(req), .xfer_read_addr_out(raddr),
    .xfer_write_addr_out(waddr), .xfer_size_out(size), .high_priority_out(hp),
    .busy_out(busy), .chain_trigger_out(chain_out), .chain_target_out(chain_tgt));
  dmacf_bus_target target (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .xfer_req_in(req),
    .delay_in(delay), .xfer_done_out(done));
  initial begin
    forever #50 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) if (chain_out === 1'b1) chain_seen <= chain_seen + 1;
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    addr <= a; rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task wait_busy(input logic v);
    for (int i = 0; i < 300 && busy !== v; i++) begin
      @(posedge mclk_in); #1;
    end
    if (busy !== v) begin
      mismatches++;
      $display("MISMATCH %0t busy wait ran out", $time);
      tally_and_finish;
    end
  endtask : wait_busy
  task quiet(input int n);
    repeat (n) begin
      @(posedge mclk_in); #1;
      chk({31'h0, req}, 32'h0, "request issued");
    end
  endtask : quiet
  function automatic logic [31:0] mk(input logic [5:0] p, input logic [3:0] c,
      input logic rs, input logic [3:0] n, input logic wi, input logic ri,
      input logic [1:0] sz, input logic hp);
    return {11'h0, p, c, rs, n, wi, ri, sz, hp, 1'b1};
  endfunction : mk
  task run(input logic [31:0] c, input logic [31:0] n, input logic [31:0] ra,
      input logic [31:0] wa);
    wr_reg(8'h04, ra);
    wr_reg(8'h08, wa);
    wr_reg(8'h0c, n);
    wr_reg(8'h00, c);
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask : run
  task t_reset;
    rd_reg(8'h00, got); chk(got, 32'h00001800, "ctrl reset");
    chk({28'h0, chain_tgt}, 32'h3, "chain reset");
    rd_reg(8'h10, got); chk(got, 32'h0, "unmapped read");
  endtask : t_reset
  task t_size;
    for (int s = 0; s < 3; s++) begin
      run(mk(6'h3f, 4'h3, 0, 0, 1, 1, 2'(s), s[0]), 3, 32'h100, 32'h200);
      chk(raddr, 32'h100 + 3 * (1 << s), "read step");
      chk(waddr, 32'h200 + 3 * (1 << s), "write step");
      chk({30'h0, size}, s, "size");
      chk({31'h0, hp}, s & 1, "priority");
    end
  endtask : t_size
  task t_fixed;
    run(mk(6'h3f, 4'h3, 0, 0, 0, 1, 2, 0), 2, 32'h300, 32'h400);
    chk(waddr, 32'h400, "write fixed");
    chk(raddr, 32'h308, "read incr");
    rd_reg(8'h04, got);
    chk(got, 32'h308, "read addr reg");
    rd_reg(8'h0c, got);
    chk(got, 32'h2, "count reg");
    run(mk(6'h3f, 4'h3, 0, 0, 1, 0, 1, 0), 2, 32'h300, 32'h400);
    chk(raddr, 32'h300, "read fixed");
    chk(waddr, 32'h404, "write incr");
    rd_reg(8'h08, got);
    chk(got, 32'h404, "write addr reg");
  endtask : t_fixed
  task t_ring;
    delay <= 4'h2;
    run(mk(6'h3f, 4'h3, 0, 4'h2, 0, 1, 0, 0), 3, 32'h1002, 32'h0);
    chk(raddr, 32'h1001, "read wrap");
    run(mk(6'h3f, 4'h3, 1, 4'h1, 1, 1, 0, 0), 2, 32'h500, 32'h2001);
    chk(waddr, 32'h2001, "write wrap");
    chk(raddr, 32'h502, "read unwrapped");
    run(mk(6'h3f, 4'h3, 0, 4'hf, 0, 1, 2, 0), 1, 32'h17ffc, 32'h0);
    chk(raddr, 32'h10000, "largest ring");
    delay <= 4'h0;
  endtask : t_ring
  task t_pace;
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk_in);
      preq <= (codes[i] <= 6'h3a) ? ~(59'h1 << codes[i]) : '1;
      tick <= (codes[i] > 6'h3a) ? ~(4'h1 << (codes[i] - 6'h3b)) : 4'hf;
      wr_reg(8'h0c, 32'h1);
      wr_reg(8'h00, mk(codes[i], 4'h3, 0, 0, 0, 0, 0, 0));
      wait_busy(1'b1);
      quiet(8);
      @(posedge mclk_in);
      preq <= '1;
      tick <= 4'hf;
      wait_busy(1'b0);
    end
  endtask : t_pace
  task t_pause;
    @(posedge mclk_in);
    preq <= '0;
    run(mk(6'h3f, 4'h3, 0, 0, 0, 0, 0, 0), 1, 32'h0, 32'h0);
    wr_reg(8'h0c, 32'h2);
    wr_reg(8'h00, mk(6'h00, 4'h3, 0, 0, 0, 0, 0, 0));
    wait_busy(1'b1);
    wr_reg(8'h00, mk(6'h00, 4'h3, 0, 0, 0, 0, 0, 0) & 32'hfffffffe);
    @(posedge mclk_in);
    preq <= '1;
    quiet(8);
    chk({31'h0, busy}, 32'h1, "busy while paused");
    rd_reg(8'h00, got);
    chk(got, 32'h01001800, "busy bit while paused");
    wr_reg(8'h00, mk(6'h00, 4'h3, 0, 0, 0, 0, 0, 0));
    wait_busy(1'b0);
    wr_reg(8'h00, 32'h00001800);
    @(posedge mclk_in); chain_in <= 1'b1;
    @(posedge mclk_in); chain_in <= 1'b0;
    quiet(4);
    chk({31'h0, busy}, 32'h0, "trigger while disabled");
    run(mk(6'h3f, 4'h3, 0, 0, 0, 0, 0, 0), 1, 32'h0, 32'h0);
    @(posedge mclk_in); chain_in <= 1'b1;
    @(posedge mclk_in); chain_in <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask : t_pause
  task t_chain;
    chk(32'(chain_seen), 32'h0, "chain while disabled");
    run(mk(6'h3f, 4'h5, 0, 0, 0, 0, 0, 0), 1, 32'h0, 32'h0);
    @(posedge mclk_in); #1;
    chk(32'(chain_seen), 32'h1, "chain pulse");
    chk({28'h0, chain_tgt}, 32'h5, "chain target");
  endtask : t_chain
  initial begin
    repeat (12) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    t_reset;
    t_size;
    t_fixed;
    t_ring;
    t_pace;
    t_pause;
    t_chain;
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
